//--- bench/proxr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module proxr_host_model (
    input  wire logic       mclk_in,
    input  wire logic [7:0] rdata_in,
    output var  logic [7:0] addr_out,
    output var  logic       wr_out,
    output var  logic       rd_out,
    output var  logic [7:0] wdata_out
);
    initial begin
        addr_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end
    // Flags are cleared by ones in the positions meant to go; while awake, a cleared bit 4 also clears bits 7 and 6.
    // Released lines show inverted values so a stale byte is never mistaken for data.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge mclk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge mclk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

//--- bench/proxr_status_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module proxr_status_regs_properties (
    input wire logic       mclk_in,
    input wire logic       reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       reg_rvalid_out,
    input wire logic       calib_done_in,
    input wire logic       emitter_on_sat_in,
    input wire logic       emitter_off_sat_in,
    input wire logic       clear_on_read_in,
    input wire logic [7:0] event_flags_out,
    input wire logic       sleep_out,
    input wire logic       soft_reset_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    logic srst_wr;
    logic ev_wr;
    logic no_src;
    assign srst_wr = reg_wr_in && reg_addr_in == proxr_pkg::ADDR_SOFT_RST && reg_wdata_in[0];
    assign ev_wr = reg_wr_in && reg_addr_in == proxr_pkg::ADDR_EVENT;
    assign no_src = !calib_done_in && !emitter_on_sat_in && !emitter_off_sat_in;
    property p_read_answer; reg_rd_in |=> reg_rvalid_out; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_no_spurious; !reg_rd_in |=> !reg_rvalid_out; endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("spurious read valid");
    property p_calib_sets; calib_done_in && !sleep_out && !srst_wr |=> event_flags_out[3]; endproperty
    a_calib_sets: assert property (p_calib_sets) else $error("calib flag not set");
    property p_on_sat; emitter_on_sat_in && !sleep_out && !srst_wr |=> event_flags_out[1]; endproperty
    a_on_sat: assert property (p_on_sat) else $error("emitter on flag not set");
    property p_off_sat; emitter_off_sat_in && !sleep_out && !srst_wr |=> event_flags_out[0]; endproperty
    a_off_sat: assert property (p_off_sat) else $error("emitter off flag not set");
    property p_w1c; ev_wr && reg_wdata_in[3] && !calib_done_in |=> !event_flags_out[3]; endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear");
    property p_read_clear;
        reg_rd_in && reg_addr_in == proxr_pkg::ADDR_EVENT && clear_on_read_in && no_src
            |=> (event_flags_out & 8'h0B) == 8'h00;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear");
    property p_high_pairs; event_flags_out[7] |-> event_flags_out[4]; endproperty
    a_high_pairs: assert property (p_high_pairs) else $error("above flag alone");
    property p_low_pairs; event_flags_out[6] |-> event_flags_out[4]; endproperty
    a_low_pairs: assert property (p_low_pairs) else $error("below flag alone");
    property p_soft_reset;
        srst_wr |=> soft_reset_out && sleep_out && event_flags_out == 8'h00;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");
    property p_rev_fixed;
        reg_rd_in && reg_addr_in == proxr_pkg::ADDR_REVISION |=> reg_rdata_out[7:3] == 5'h00;
    endproperty
    a_rev_fixed: assert property (p_rev_fixed) else $error("revision field moved");
endmodule
bind proxr_status_regs proxr_status_regs_properties i_props (.mclk_in, .reset_in, .reg_addr_in,
    .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .calib_done_in,
    .emitter_on_sat_in, .emitter_off_sat_in, .clear_on_read_in, .event_flags_out, .sleep_out,
    .soft_reset_out);
`default_nettype wire

//--- bench/proxr_status_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module proxr_status_regs_test;
    logic        mclk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        conv_done = 1'b0;
    logic        calib = 1'b0;
    logic        on_sat = 1'b0;
    logic        off_sat = 1'b0;
    logic        wake = 1'b0;
    logic        apc_off = 1'b0;
    logic        cor = 1'b0;
    logic        aoa = 1'b0;
    logic [3:0]  pers = 4'h1;
    logic [9:0]  adc = 10'h000;
    logic [6:0]  pulses = 7'h01;
    logic [15:0] hi = 16'hFFFF;
    logic [15:0] lo = 16'h0000;
    wire  logic [7:0]  addr, wdata, rdata, flags;
    wire  logic        wr, rd, rvalid, sleep, srst;
    wire  logic [13:0] res;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          cycles = 0;
    always #20 mclk_in = ~mclk_in;
    proxr_host_model i_host (.mclk_in(mclk_in), .rdata_in(rdata), .addr_out(addr),
        .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
    // Identification parameters are arbitrary values.
    proxr_status_regs #(.REVISION_NUMBER(3'h3), .TYPE_CODE(6'h15), .VERSION_NUMBER(4'h9)) i_dut (
        .mclk_in(mclk_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .conv_done_in(conv_done), .adc_value_in(adc), .pulse_count_in(pulses),
        .auto_pulse_off_in(apc_off), .auto_offset_adjust_in(aoa), .clear_on_read_in(cor),
        .persist_count_in(pers), .high_threshold_in(hi), .low_threshold_in(lo),
        .calib_done_in(calib), .emitter_on_sat_in(on_sat), .emitter_off_sat_in(off_sat),
        .wake_in(wake), .event_flags_out(flags), .result_out(res), .sleep_out(sleep),
        .soft_reset_out(srst));
    task automatic complete_run();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.read_reg(a, d);
        check8(d, exp);
    endtask
    task automatic events(input logic [2:0] m);
        @(posedge mclk_in);
        {calib, on_sat, off_sat} <= m;
        @(posedge mclk_in);
        {calib, on_sat, off_sat} <= 3'h0;
    endtask
    // Waiting past the slowest result keeps conversions further apart than the divider needs.
    task automatic convert(input logic off, input logic [9:0] v, input logic [6:0] n);
        @(posedge mclk_in);
        apc_off <= off;
        adc <= v;
        pulses <= n;
        conv_done <= 1'b1;
        @(posedge mclk_in);
        conv_done <= 1'b0;
        repeat (17) @(posedge mclk_in);
    endtask
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        repeat (6) @(posedge mclk_in);
        reset_in <= 1'b0;
        rd_check(proxr_pkg::ADDR_REVISION, 8'h03);
        rd_check(proxr_pkg::ADDR_TYPE, 8'h54);
        rd_check(proxr_pkg::ADDR_VERSION, 8'h09);
        i_host.write_reg(proxr_pkg::ADDR_REVISION, 8'hFF);
        rd_check(proxr_pkg::ADDR_REVISION, 8'h03);
        i_host.write_reg(proxr_pkg::ADDR_RES_LO, 8'hFF);
        rd_check(proxr_pkg::ADDR_RES_LO, 8'h00);
        rd_check(8'h80, 8'h00);
        @(posedge mclk_in);
        wake <= 1'b1;
        @(posedge mclk_in);
        wake <= 1'b0;
        events(3'b111);
        rd_check(proxr_pkg::ADDR_EVENT, 8'h0B);
        i_host.write_reg(proxr_pkg::ADDR_EVENT, 8'h02);
        rd_check(proxr_pkg::ADDR_EVENT, 8'h09);
        @(posedge mclk_in);
        cor <= 1'b1;
        rd_check(proxr_pkg::ADDR_EVENT, 8'h09);
        rd_check(proxr_pkg::ADDR_EVENT, 8'h00);
        @(posedge mclk_in);
        cor <= 1'b0;
        fork
            events(3'b100);
            i_host.write_reg(proxr_pkg::ADDR_EVENT, 8'h08);
        join
        rd_check(proxr_pkg::ADDR_EVENT, 8'h08);
        i_host.write_reg(proxr_pkg::ADDR_EVENT, 8'hFF);
        hi <= 16'h02F0;
        lo <= 16'h02C0;
        convert(1'b1, 10'h2D7, 7'h08);
        rd_check(proxr_pkg::ADDR_RES_LO, 8'hB5);
        rd_check(proxr_pkg::ADDR_RES_HI, 8'h03);
        rd_check(proxr_pkg::ADDR_EVENT, 8'h70);
        i_host.write_reg(proxr_pkg::ADDR_EVENT, 8'hFF);
        hi <= 16'h0100;
        lo <= 16'h0000;
        convert(1'b0, 10'h3FF, 7'h08);
        rd_check(proxr_pkg::ADDR_EVENT, 8'h90);
        rd_check(proxr_pkg::ADDR_RES_LO, 8'hFE);
        check8(res[7:0], 8'hFE);
        check8({2'h0, res[13:8]}, 8'h07);
        convert(1'b0, 10'h001, 7'h10);
        rd_check(proxr_pkg::ADDR_RES_HI, 8'h07);
        i_host.write_reg(proxr_pkg::ADDR_EVENT, 8'h10);
        rd_check(proxr_pkg::ADDR_EVENT, 8'h00);
        rd_check(proxr_pkg::ADDR_RES_LO, 8'h01);
        rd_check(proxr_pkg::ADDR_RES_HI, 8'h00);
        aoa <= 1'b1;
        convert(1'b1, 10'h000, 7'h08);
        rd_check(proxr_pkg::ADDR_EVENT, 8'h04);
        i_host.write_reg(proxr_pkg::ADDR_EVENT, 8'hFF);
        pers <= 4'h2;
        convert(1'b0, 10'h3FF, 7'h08);
        rd_check(proxr_pkg::ADDR_EVENT, 8'h00);
        convert(1'b0, 10'h3FF, 7'h08);
        rd_check(proxr_pkg::ADDR_EVENT, 8'h90);
        events(3'b100);
        i_host.write_reg(proxr_pkg::ADDR_SOFT_RST, 8'h01);
        rd_check(proxr_pkg::ADDR_SOFT_RST, 8'h00);
        check8({7'h00, sleep}, 8'h01);
        rd_check(proxr_pkg::ADDR_EVENT, 8'h00);
        rd_check(proxr_pkg::ADDR_RES_LO, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire

//--- hw/proxr_pkg.sv
package proxr_pkg;
    localparam logic [7:0] ADDR_REVISION = 8'h91;
    localparam logic [7:0] ADDR_TYPE     = 8'h92;
    localparam logic [7:0] ADDR_EVENT    = 8'h9B;
    localparam logic [7:0] ADDR_RES_LO   = 8'h9C;
    localparam logic [7:0] ADDR_RES_HI   = 8'h9D;
    localparam logic [7:0] ADDR_VERSION  = 8'hA6;
    localparam logic [7:0] ADDR_SOFT_RST = 8'hA8;

    localparam int BIT_ABOVE_HIGH  = 7;
    localparam int BIT_BELOW_LOW   = 6;
    localparam int BIT_SATURATION  = 5;
    localparam int BIT_PROX_EVENT  = 4;
    localparam int BIT_CALIB_DONE  = 3;
    localparam int BIT_ZERO_DETECT = 2;
    localparam int BIT_EMIT_ON_SAT = 1;
    localparam int BIT_EMIT_OFF_SAT = 0;
    localparam int BIT_SOFT_RST    = 0;
    localparam int TYPE_LSB        = 2;

    localparam int ADC_W   = 10;
    localparam int RES_W   = 14;
    localparam int PULSE_W = 7;
    localparam int SCALE_SHIFT = 4;
    localparam int THR_W   = 16;
    localparam int PERS_W  = 4;

    localparam logic [7:0]       EVENT_RESET  = 8'h00;
    localparam logic [RES_W-1:0] RESULT_RESET = 14'h0000;
    localparam logic [7:0]       BYTE_ZERO    = 8'h00;
    localparam logic [3:0]       DIV_STEPS    = 4'hE;

    typedef enum logic [1:0] {
        PROXR_IDLE = 2'b00,
        PROXR_DIV  = 2'b01,
        PROXR_DONE = 2'b10
    } proxr_state_t;
endpackage

//--- hw/proxr_res_if.sv
`timescale 1ns/1ps
`default_nettype none
interface proxr_res_if;
    logic                         res_valid;
    logic [proxr_pkg::RES_W-1:0]  result;
    logic                         res_apc_off;
    logic                         above_high;
    logic                         below_low;
    logic                         soft_rst;

    modport calc (input soft_rst, output res_valid, result, res_apc_off, above_high, below_low);
    modport regs (output soft_rst, input res_valid, result, res_apc_off, above_high, below_low);
endinterface
`default_nettype wire

//--- hw/proxr_result_calc.sv
`timescale 1ns/1ps
`default_nettype none
module proxr_result_calc (
    input  wire logic                             mclk_in,
    input  wire logic                             reset_in,
    input  wire logic                             conv_done_in,
    input  wire logic [proxr_pkg::ADC_W-1:0]      adc_value_in,
    input  wire logic [proxr_pkg::PULSE_W-1:0]    pulse_count_in,
    input  wire logic                             auto_pulse_off_in,
    input  wire logic [proxr_pkg::THR_W-1:0]      high_threshold_in,
    input  wire logic [proxr_pkg::THR_W-1:0]      low_threshold_in,
    proxr_res_if.calc                             res
);
    proxr_pkg::proxr_state_t       state_r;
    logic [proxr_pkg::RES_W-1:0]   quo_r;
    logic [7:0]                    rem_r;
    logic [proxr_pkg::PULSE_W-1:0] div_r;
    logic [3:0]                    step_r;
    logic                          apc_off_r;
    logic [8:0]                    rem_shift;
    logic [8:0]                    diff;

    // Pulse-control-off mode compares only the upper eight bits to the low threshold bytes.
    function automatic logic over_thr(input logic [proxr_pkg::RES_W-1:0] v,
                                      input logic [proxr_pkg::THR_W-1:0] t,
                                      input logic off);
        if (off) begin
            over_thr = v[proxr_pkg::ADC_W-1:2] > t[7:0];
        end else begin
            over_thr = {2'b00, v} > t;
        end
    endfunction

    always_comb begin
        rem_shift = {rem_r, quo_r[proxr_pkg::RES_W-1]};
        diff      = rem_shift - {2'b00, div_r};
    end

    // A multi-cycle divider saves area; conversions arrive far slower than fourteen cycles.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r   <= proxr_pkg::PROXR_IDLE;
            quo_r     <= proxr_pkg::RESULT_RESET;
            rem_r     <= 8'h00;
            div_r     <= 7'h01;
            step_r    <= 4'h0;
            apc_off_r <= 1'b0;
        end else if (res.soft_rst) begin
            state_r   <= proxr_pkg::PROXR_IDLE;
            quo_r     <= proxr_pkg::RESULT_RESET;
            rem_r     <= 8'h00;
            step_r    <= 4'h0;
        end else begin
            unique case (state_r)
                proxr_pkg::PROXR_IDLE: begin
                    if (conv_done_in) begin
                        apc_off_r <= auto_pulse_off_in;
                        rem_r     <= 8'h00;
                        step_r    <= 4'h0;
                        div_r     <= (pulse_count_in == 7'h00) ? 7'h01 : pulse_count_in;
                        if (auto_pulse_off_in) begin
                            quo_r   <= {4'h0, adc_value_in};
                            state_r <= proxr_pkg::PROXR_DONE;
                        end else begin
                            quo_r   <= {adc_value_in, 4'h0};
                            state_r <= proxr_pkg::PROXR_DIV;
                        end
                    end
                end
                proxr_pkg::PROXR_DIV: begin
                    if (!diff[8]) begin
                        rem_r <= diff[7:0];
                    end else begin
                        rem_r <= rem_shift[7:0];
                    end
                    quo_r  <= {quo_r[proxr_pkg::RES_W-2:0], ~diff[8]};
                    step_r <= step_r + 4'h1;
                    if (step_r == proxr_pkg::DIV_STEPS - 4'h1) begin
                        state_r <= proxr_pkg::PROXR_DONE;
                    end
                end
                proxr_pkg::PROXR_DONE: begin
                    state_r <= proxr_pkg::PROXR_IDLE;
                end
                default: begin
                    state_r <= proxr_pkg::PROXR_IDLE;
                end
            endcase
        end
    end

    assign res.res_valid   = (state_r == proxr_pkg::PROXR_DONE);
    assign res.result      = quo_r;
    assign res.res_apc_off = apc_off_r;
    assign res.above_high  = over_thr(quo_r, high_threshold_in, apc_off_r);
    assign res.below_low   = over_thr(quo_r, low_threshold_in, apc_off_r) == 1'b0
                             && (apc_off_r ? quo_r[proxr_pkg::ADC_W-1:2] != low_threshold_in[7:0]
                                           : {2'b00, quo_r} != low_threshold_in);
endmodule
`default_nettype wire

//--- hw/proxr_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module proxr_status_regs #(
    parameter logic [2:0] REVISION_NUMBER = 3'h5,
    parameter logic [5:0] TYPE_CODE       = 6'h2A,
    parameter logic [3:0] VERSION_NUMBER  = 4'h7
) (
    input  wire logic                             mclk_in,
    input  wire logic                             reset_in,
    input  wire logic [7:0]                       reg_addr_in,
    input  wire logic                             reg_wr_in,
    input  wire logic                             reg_rd_in,
    input  wire logic [7:0]                       reg_wdata_in,
    output var  logic [7:0]                       reg_rdata_out,
    output var  logic                             reg_rvalid_out,
    input  wire logic                             conv_done_in,
    input  wire logic [proxr_pkg::ADC_W-1:0]      adc_value_in,
    input  wire logic [proxr_pkg::PULSE_W-1:0]    pulse_count_in,
    input  wire logic                             auto_pulse_off_in,
    input  wire logic                             auto_offset_adjust_in,
    input  wire logic                             clear_on_read_in,
    input  wire logic [proxr_pkg::PERS_W-1:0]     persist_count_in,
    input  wire logic [proxr_pkg::THR_W-1:0]      high_threshold_in,
    input  wire logic [proxr_pkg::THR_W-1:0]      low_threshold_in,
    input  wire logic                             calib_done_in,
    input  wire logic                             emitter_on_sat_in,
    input  wire logic                             emitter_off_sat_in,
    input  wire logic                             wake_in,
    output var  logic [7:0]                       event_flags_out,
    output var  logic [proxr_pkg::RES_W-1:0]      result_out,
    output var  logic                             sleep_out,
    output var  logic                             soft_reset_out
);
    // The identification parameter defaults are arbitrary values.

    proxr_res_if res ();

    logic [7:0]                    flags_r;
    logic [7:0]                    flags_nxt;
    logic [7:0]                    flag_set;
    logic [7:0]                    flag_clr;
    logic [proxr_pkg::RES_W-1:0]   result_r;
    logic                          res_apc_off_r;
    logic [7:0]                    shadow_hi_r;
    logic [proxr_pkg::PERS_W:0]    pers_cnt_r;
    logic [proxr_pkg::PERS_W:0]    pers_cnt_nxt;
    logic [proxr_pkg::PERS_W:0]    pers_need;
    logic                          out_of_range;
    logic                          prox_hit;
    logic                          sat_on_seen_r;
    logic                          sat_off_seen_r;
    logic                          zero_pending_r;
    logic                          soft_rst_req;
    logic                          wr_event;
    logic                          rd_event;
    logic                          rd_low;
    logic [7:0]                    rdata_nxt;

    // Result bytes depend on the pulse-control mode the conversion was made in.
    function automatic logic [7:0] res_low_byte(input logic [proxr_pkg::RES_W-1:0] v,
                                                input logic off);
        if (off) begin
            res_low_byte = v[proxr_pkg::ADC_W-1:2];
        end else begin
            res_low_byte = v[7:0];
        end
    endfunction

    function automatic logic [7:0] res_high_byte(input logic [proxr_pkg::RES_W-1:0] v,
                                                 input logic off);
        if (off) begin
            res_high_byte = {6'h00, v[1:0]};
        end else begin
            res_high_byte = {2'h0, v[proxr_pkg::RES_W-1:8]};
        end
    endfunction

    proxr_result_calc u_calc (
        .mclk_in           (mclk_in),
        .reset_in          (reset_in),
        .conv_done_in      (conv_done_in && !sleep_out),
        .adc_value_in      (adc_value_in),
        .pulse_count_in    (pulse_count_in),
        .auto_pulse_off_in (auto_pulse_off_in),
        .high_threshold_in (high_threshold_in),
        .low_threshold_in  (low_threshold_in),
        .res               (res.calc)
    );

    always_comb begin
        soft_rst_req = reg_wr_in && reg_addr_in == proxr_pkg::ADDR_SOFT_RST
                       && reg_wdata_in[proxr_pkg::BIT_SOFT_RST];
        wr_event     = reg_wr_in && reg_addr_in == proxr_pkg::ADDR_EVENT;
        rd_event     = reg_rd_in && reg_addr_in == proxr_pkg::ADDR_EVENT;
        rd_low       = reg_rd_in && reg_addr_in == proxr_pkg::ADDR_RES_LO;
    end

    assign res.soft_rst = soft_rst_req;

    // Persistence: consecutive out-of-range results, a count of zero fires on every one.
    always_comb begin
        out_of_range = res.above_high || res.below_low;
        pers_need    = (persist_count_in == 4'h0) ? 5'h01 : {1'b0, persist_count_in};
        if (!out_of_range) begin
            pers_cnt_nxt = 5'h00;
        end else if (pers_cnt_r == 5'h1F) begin
            pers_cnt_nxt = pers_cnt_r;
        end else begin
            pers_cnt_nxt = pers_cnt_r + 5'h01;
        end
        prox_hit = res.res_valid && out_of_range && pers_cnt_nxt >= pers_need;
    end

    always_comb begin
        flag_set = 8'h00;
        flag_set[proxr_pkg::BIT_PROX_EVENT]   = prox_hit;
        flag_set[proxr_pkg::BIT_ABOVE_HIGH]   = prox_hit && res.above_high;
        flag_set[proxr_pkg::BIT_BELOW_LOW]    = prox_hit && res.below_low;
        flag_set[proxr_pkg::BIT_SATURATION]   = res.res_valid
                                                && (sat_on_seen_r || sat_off_seen_r);
        flag_set[proxr_pkg::BIT_CALIB_DONE]   = calib_done_in;
        flag_set[proxr_pkg::BIT_ZERO_DETECT]  = res.res_valid && zero_pending_r;
        flag_set[proxr_pkg::BIT_EMIT_ON_SAT]  = emitter_on_sat_in;
        flag_set[proxr_pkg::BIT_EMIT_OFF_SAT] = emitter_off_sat_in;
        flag_clr = 8'h00;
        if (wr_event) begin
            flag_clr = reg_wdata_in;
        end
        if (rd_event && clear_on_read_in) begin
            flag_clr = 8'hFF;
        end
        flags_nxt = (flags_r & ~flag_clr) | flag_set;
        if (!flags_nxt[proxr_pkg::BIT_PROX_EVENT]) begin
            flags_nxt[proxr_pkg::BIT_ABOVE_HIGH] = 1'b0;
            flags_nxt[proxr_pkg::BIT_BELOW_LOW]  = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            flags_r <= proxr_pkg::EVENT_RESET;
        end else if (soft_rst_req) begin
            flags_r <= proxr_pkg::EVENT_RESET;
        end else if (!sleep_out) begin
            flags_r <= flags_nxt;
        end else begin
            flags_r <= flags_r & ~flag_clr;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            pers_cnt_r <= 5'h00;
        end else if (soft_rst_req) begin
            pers_cnt_r <= 5'h00;
        end else if (res.res_valid) begin
            pers_cnt_r <= pers_cnt_nxt;
        end
    end

    // Saturation seen during a cycle is reported when that cycle's result lands.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            sat_on_seen_r  <= 1'b0;
            sat_off_seen_r <= 1'b0;
            zero_pending_r <= 1'b0;
        end else if (soft_rst_req || res.res_valid) begin
            sat_on_seen_r  <= 1'b0;
            sat_off_seen_r <= 1'b0;
            zero_pending_r <= 1'b0;
        end else begin
            if (emitter_on_sat_in) begin
                sat_on_seen_r <= 1'b1;
            end
            if (emitter_off_sat_in) begin
                sat_off_seen_r <= 1'b1;
            end
            if (conv_done_in && !sleep_out && auto_offset_adjust_in
                && adc_value_in == 10'h000) begin
                zero_pending_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            result_r      <= proxr_pkg::RESULT_RESET;
            res_apc_off_r <= 1'b0;
        end else if (soft_rst_req) begin
            result_r      <= proxr_pkg::RESULT_RESET;
            res_apc_off_r <= 1'b0;
        end else if (res.res_valid) begin
            result_r      <= res.result;
            res_apc_off_r <= res.res_apc_off;
        end
    end

    // The shadow keeps a later conversion from tearing a low-then-high byte pair.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            shadow_hi_r <= proxr_pkg::BYTE_ZERO;
        end else if (soft_rst_req) begin
            shadow_hi_r <= proxr_pkg::BYTE_ZERO;
        end else if (rd_low) begin
            shadow_hi_r <= res_high_byte(result_r, res_apc_off_r);
        end
    end

    // Sleep is the default state; the power-up request brings the block back.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            sleep_out <= 1'b1;
        end else if (soft_rst_req) begin
            sleep_out <= 1'b1;
        end else if (wake_in) begin
            sleep_out <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            soft_reset_out <= 1'b0;
        end else begin
            soft_reset_out <= soft_rst_req;
        end
    end

    // Read-only registers have no write path at all, so writes to them vanish.
    always_comb begin
        unique case (reg_addr_in)
            proxr_pkg::ADDR_REVISION: rdata_nxt = {5'h00, REVISION_NUMBER};
            proxr_pkg::ADDR_TYPE:     rdata_nxt = {TYPE_CODE, 2'h0};
            proxr_pkg::ADDR_EVENT:    rdata_nxt = flags_r;
            proxr_pkg::ADDR_RES_LO:   rdata_nxt = res_low_byte(result_r, res_apc_off_r);
            proxr_pkg::ADDR_RES_HI:   rdata_nxt = shadow_hi_r;
            proxr_pkg::ADDR_VERSION:  rdata_nxt = {4'h0, VERSION_NUMBER};
            default:                  rdata_nxt = proxr_pkg::BYTE_ZERO;
        endcase
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out  <= proxr_pkg::BYTE_ZERO;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= rdata_nxt;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            event_flags_out <= proxr_pkg::EVENT_RESET;
            result_out      <= proxr_pkg::RESULT_RESET;
        end else begin
            result_out <= res.result;
            // The copy follows every branch of the event register, soft reset and sleep too.
            if (soft_rst_req) begin
                event_flags_out <= proxr_pkg::EVENT_RESET;
            end else if (!sleep_out) begin
                event_flags_out <= flags_nxt;
            end else begin
                event_flags_out <= flags_r & ~flag_clr;
            end
        end
    end
endmodule
`default_nettype wire
